// ---- hdl/boundary_scan_pattern_engine.sv ----
// Scan device end: port state machine, registers and boundary-run engine
//
// Summary of operation
// - Toggle mode: input cells load pins each rise.
// - Toggle mode: output cells invert, latch at fall.
// - 40-bit pattern generator, latched at falling edge.
// - All-zero seed stays zero in generators.
// - Controller shifts a seed in beforehand.
// - 40-bit signature folds input pins each rise.
// - 40-bit signature: output shadow latches hold.
// - Combined modes: 20-bit signature on input cells.
// - Combined random: 20-bit generator on output cells.
// - Combined count: 20-bit counter on output cells.
// - Serial in, mode, pins sampled at rise.
// - Serial out and pins change at fall.
// - Controller changes mode select while clock low.
// - Shift states pass one bit per clock.
// - Instruction capture loads 10000001.
// - Mode-select walk from reset to capture.
// - Codes X00 toggle, X01 random, X10 signature.
// - Codes 011 and 111 select combined modes.
// - Runs only in run-test instruction, idle.
// - Equal direction enables freeze the run.
`timescale 1ns/1ps
module boundary_scan_pattern_engine
    import scan_test_pkg::*;
(
    // Clock and reset
    input  wire logic            i_clk,
    input  wire logic            i_reset_n,
    // Test port
    test_port_if.dev             tp,
    // Direction enables
    input  wire logic            i_a_to_b_output_enable_n,
    input  wire logic            i_b_to_a_output_enable_n,
    // Port A pins
    input  wire logic [HALF-1:0] i_a_pins,
    output logic      [HALF-1:0] o_a_pins,
    output logic      [HALF-1:0] o_a_oe,
    // Port B pins
    input  wire logic [HALF-1:0] i_b_pins,
    output logic      [HALF-1:0] o_b_pins,
    output logic      [HALF-1:0] o_b_oe
);
    tap_state_t        state_q;
    logic              tck_q, rise, fall;
    logic [IR_W-1:0]   ir_q, ir_sh_q;
    logic [CTRL_W-1:0] ctrl_q, ctrl_sh_q;
    logic              byp_q, tdo_q, tdo_oe_q;
    logic [CELLS-1:0]  bnd_q, shadow_q, run_next, pin_place;
    logic [HALF-1:0]   a_meta_q, a_sync_q, b_meta_q, b_sync_q;
    logic [1:0]        oe_meta_q, oe_sync_q;
    logic [HALF-1:0]   norm_a_q, norm_b_q;
    logic              a_to_b, dir_ok, run_active, test_mode;
    logic [HALF-1:0]   in_pins, in_cells, out_cells, new_in, new_out;

    function automatic tap_state_t tap_next(input tap_state_t s,
                                            input logic tms);
        unique case (s)
            TLR:      tap_next = tms ? TLR      : RTI;
            RTI:      tap_next = tms ? SEL_DR   : RTI;
            SEL_DR:   tap_next = tms ? SEL_IR   : CAP_DR;
            CAP_DR:   tap_next = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: tap_next = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: tap_next = tms ? UPD_DR   : PAUSE_DR;
            PAUSE_DR: tap_next = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: tap_next = tms ? UPD_DR   : SHIFT_DR;
            UPD_DR:   tap_next = tms ? SEL_DR   : RTI;
            SEL_IR:   tap_next = tms ? TLR      : CAP_IR;
            CAP_IR:   tap_next = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: tap_next = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: tap_next = tms ? UPD_IR   : PAUSE_IR;
            PAUSE_IR: tap_next = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: tap_next = tms ? UPD_IR   : SHIFT_IR;
            UPD_IR:   tap_next = tms ? SEL_DR   : RTI;
        endcase
    endfunction : tap_next

    // Galois steps; a zero state maps to zero, so an empty seed stalls
    function automatic logic [39:0] lfsr40(input logic [39:0] s);
        lfsr40 = {s[38:0], 1'b0} ^ (s[39] ? TAPS40 : '0);
    endfunction : lfsr40

    function automatic logic [19:0] lfsr20(input logic [19:0] s);
        lfsr20 = {s[18:0], 1'b0} ^ (s[19] ? TAPS20 : '0);
    endfunction : lfsr20

    // Edge detection of the controller-made test clock
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tck_q <= 1'b0;
        end else begin
            tck_q <= tp.tck;
        end
    end
    assign rise = tp.tck & ~tck_q;
    assign fall = ~tp.tck & tck_q;

    // Pins come from another board domain
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            a_meta_q  <= '0;
            a_sync_q  <= '0;
            b_meta_q  <= '0;
            b_sync_q  <= '0;
            oe_meta_q <= 2'h3;
            oe_sync_q <= 2'h3;
        end else begin
            a_meta_q  <= i_a_pins;
            a_sync_q  <= a_meta_q;
            b_meta_q  <= i_b_pins;
            b_sync_q  <= b_meta_q;
            oe_meta_q <= {i_b_to_a_output_enable_n,
                          i_a_to_b_output_enable_n};
            oe_sync_q <= oe_meta_q;
        end
    end

    assign a_to_b     = ~oe_sync_q[0];
    assign dir_ok     = oe_sync_q[0] ^ oe_sync_q[1];
    assign test_mode  = (ir_q == OP_RUN_TEST);
    assign run_active = test_mode && state_q == RTI && dir_ok;
    assign in_pins    = a_to_b ? a_sync_q : b_sync_q;
    assign in_cells   = a_to_b ? bnd_q[HALF-1:0] : bnd_q[CELLS-1:HALF];
    assign out_cells  = a_to_b ? bnd_q[CELLS-1:HALF] : bnd_q[HALF-1:0];
    assign pin_place  = a_to_b ? {{HALF{1'b0}}, in_pins}
                               : {in_pins, {HALF{1'b0}}};

    // Next contents of the boundary cells for one run step
    always_comb begin
        new_in   = in_cells;
        new_out  = out_cells;
        if (ctrl_q == CTRL_SIG_RAND) begin
            new_in  = lfsr20(in_cells) ^ in_pins;
            new_out = lfsr20(out_cells);
        end else if (ctrl_q == CTRL_SIG_CNT) begin
            new_in  = lfsr20(in_cells) ^ in_pins;
            new_out = out_cells + 20'h1;
        end else if (ctrl_q[1:0] == CTRL_TOGGLE) begin
            new_in  = in_pins;
            new_out = ~out_cells;
        end
        run_next = a_to_b ? {new_out, new_in} : {new_in, new_out};
        if (ctrl_q[1:0] == CTRL_RANDOM) begin
            run_next = lfsr40(bnd_q);
        end else if (ctrl_q == {1'b0, CTRL_SIGN} ||
                     ctrl_q == {1'b1, CTRL_SIGN}) begin
            run_next = lfsr40(bnd_q) ^ pin_place;
        end
    end

    // Port state machine, advanced at the test clock rise
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= TLR;
        end else if (rise) begin
            state_q <= tap_next(state_q, tp.tms);
        end
    end

    // Instruction shift stage and active instruction
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ir_sh_q <= '0;
            ir_q    <= OP_BYPASS;
        end else if (rise && state_q == CAP_IR) begin
            ir_sh_q <= IR_CAPTURE;
        end else if (rise && state_q == SHIFT_IR) begin
            ir_sh_q <= {tp.tdi, ir_sh_q[IR_W-1:1]};
        end else if (fall && state_q == UPD_IR) begin
            ir_q    <= ir_sh_q;
        end else if (rise && state_q == TLR) begin
            ir_q    <= OP_BYPASS;
        end
    end

    // Test control register and bypass bit
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_sh_q <= CTRL_RESET;
            ctrl_q    <= CTRL_RESET;
            byp_q     <= 1'b0;
        end else if (rise && state_q == CAP_DR) begin
            ctrl_sh_q <= ctrl_q;
            byp_q     <= 1'b0;
        end else if (rise && state_q == SHIFT_DR) begin
            byp_q <= tp.tdi;
            if (ir_q == OP_CONTROL) begin
                ctrl_sh_q <= {tp.tdi, ctrl_sh_q[CTRL_W-1:1]};
            end
        end else if (fall && state_q == UPD_DR && ir_q == OP_CONTROL) begin
            ctrl_q <= ctrl_sh_q;
        end
    end

    // Boundary shift stages: serial path and run steps
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bnd_q <= '0;
        end else if (rise && ir_q == OP_BOUNDARY) begin
            if (state_q == CAP_DR) begin
                bnd_q <= {b_sync_q, a_sync_q};
            end else if (state_q == SHIFT_DR) begin
                bnd_q <= {tp.tdi, bnd_q[CELLS-1:1]};
            end
        end else if (rise && run_active) begin
            bnd_q <= run_next;
        end
    end

    // Shadow latches follow the output cells at the fall, except in
    // the 40-bit signature, where the pins must stay put
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shadow_q <= '0;
        end else if (fall && ir_q == OP_BOUNDARY && state_q == UPD_DR) begin
            shadow_q <= bnd_q;
        end else if (fall && run_active &&
                     ctrl_q[1:0] != CTRL_SIGN) begin
            if (a_to_b) begin
                shadow_q[CELLS-1:HALF] <= bnd_q[CELLS-1:HALF];
            end else begin
                shadow_q[HALF-1:0] <= bnd_q[HALF-1:0];
            end
        end
    end

    // Serial out changes at the fall only
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (fall) begin
            tdo_oe_q <= (state_q == SHIFT_IR || state_q == SHIFT_DR);
            if (state_q == SHIFT_IR) begin
                tdo_q <= ir_sh_q[0];
            end else if (ir_q == OP_BOUNDARY) begin
                tdo_q <= bnd_q[0];
            end else if (ir_q == OP_CONTROL) begin
                tdo_q <= ctrl_sh_q[0];
            end else begin
                tdo_q <= byp_q;
            end
        end
    end
    assign tp.tdo    = tdo_q;
    assign tp.tdo_oe = tdo_oe_q;

    // Normal transceiver path, one flop of latency
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            norm_a_q <= '0;
            norm_b_q <= '0;
        end else begin
            norm_a_q <= b_sync_q;
            norm_b_q <= a_sync_q;
        end
    end

    assign o_a_pins = test_mode ? shadow_q[HALF-1:0] : norm_a_q;
    assign o_b_pins = test_mode ? shadow_q[CELLS-1:HALF] : norm_b_q;
    assign o_a_oe   = {HALF{~oe_sync_q[1]}};
    assign o_b_oe   = {HALF{~oe_sync_q[0]}};
endmodule : boundary_scan_pattern_engine

// ---- hdl/scan_test_pkg.sv ----
// Shared constants and types for the boundary-run test engine and its controller
package scan_test_pkg;
    // Boundary register layout: cells 19..0 face port A, 39..20 face port B
    localparam int CELLS  = 40;
    localparam int HALF   = 20;
    localparam int IR_W   = 8;
    localparam int CTRL_W = 3;

    // Instruction register
    localparam logic [7:0] IR_CAPTURE  = 8'h81;
    localparam logic [7:0] OP_BYPASS   = 8'hff;
    localparam logic [7:0] OP_BOUNDARY = 8'h82;
    localparam logic [7:0] OP_RUN_TEST = 8'h09;
    localparam logic [7:0] OP_CONTROL  = 8'h8e;

    // Test control register codes, bits 2..0
    localparam logic [1:0] CTRL_TOGGLE   = 2'h0;
    localparam logic [1:0] CTRL_RANDOM   = 2'h1;
    localparam logic [1:0] CTRL_SIGN     = 2'h2;
    localparam logic [2:0] CTRL_SIG_RAND = 3'h3;
    localparam logic [2:0] CTRL_SIG_CNT  = 3'h7;
    localparam logic [2:0] CTRL_RESET    = 3'h0;

    // Feedback taps, Galois form
    localparam logic [39:0] TAPS40 = 40'ha0_0014_0000;
    localparam logic [19:0] TAPS20 = 20'h9_0000;

    // Test clock timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int TCK_HALF_NS   = 20;
    localparam int TCK_HALF_CYC  =
        (TCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
        UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR,
        UPD_IR
    } tap_state_t;
endpackage : scan_test_pkg

// ---- hdl/test_port_if.sv ----
// Four-wire test port between controller and device
`timescale 1ns/1ps
interface test_port_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;

    modport ctrl (output tck, output tms, output tdi,
                  input tdo, input tdo_oe);
    modport dev  (input tck, input tms, input tdi,
                  output tdo, output tdo_oe);
endinterface : test_port_if

// ---- hdl/test_bus_controller.sv ----
// Controller end: makes the test clock and runs one clock per request
`timescale 1ns/1ps
module test_bus_controller
    import scan_test_pkg::*;
#(
    parameter int HALF_CYC = TCK_HALF_CYC
)
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    // Test port
    test_port_if.ctrl tp,
    // Request
    input  wire logic i_req,
    input  wire logic i_tms,
    input  wire logic i_tdi,
    output logic      o_ready,
    // Answer
    output logic      o_done,
    output logic      o_tdo,
    output logic      o_tdo_valid
);
    typedef enum logic [1:0] {IDLE, LOW, HIGH} ctl_state_t;

    ctl_state_t  state_q;
    logic [15:0] cnt_q;
    logic        tck_q;
    logic        tms_q;
    logic        tdi_q;
    logic        done_q;
    logic        tdo_q;
    logic        tdo_valid_q;

    // Test clock divider; bits change only while the clock is low
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= IDLE;
            cnt_q   <= '0;
            tck_q   <= 1'b0;
            tms_q   <= 1'b1;
            tdi_q   <= 1'b0;
        end else begin
            unique case (state_q)
                IDLE: if (i_req) begin
                    tms_q   <= i_tms;
                    tdi_q   <= i_tdi;
                    cnt_q   <= 16'(HALF_CYC - 1);
                    state_q <= LOW;
                end
                LOW: if (cnt_q == '0) begin
                    tck_q   <= 1'b1;
                    cnt_q   <= 16'(HALF_CYC - 1);
                    state_q <= HIGH;
                end else begin
                    cnt_q <= cnt_q - 16'h1;
                end
                HIGH: if (cnt_q == '0) begin
                    tck_q   <= 1'b0;
                    state_q <= IDLE;
                end else begin
                    cnt_q <= cnt_q - 16'h1;
                end
                default: state_q <= IDLE;
            endcase
        end
    end

    // Serial out is stable around the rise; sample it there
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tdo_q       <= 1'b0;
            tdo_valid_q <= 1'b0;
            done_q      <= 1'b0;
        end else begin
            done_q <= (state_q == HIGH && cnt_q == '0);
            if (state_q == LOW && cnt_q == '0) begin
                tdo_q       <= tp.tdo;
                tdo_valid_q <= tp.tdo_oe;
            end
        end
    end

    assign tp.tck      = tck_q;
    assign tp.tms      = tms_q;
    assign tp.tdi      = tdi_q;
    assign o_ready     = (state_q == IDLE);
    assign o_done      = done_q;
    assign o_tdo       = tdo_q;
    assign o_tdo_valid = tdo_valid_q;
endmodule : test_bus_controller

// ---- dv/scan_port_props.sv ----
// Checker for the four-wire test port between controller and device
`timescale 1ns/1ps
module scan_port_props #(
    parameter int HALF_CYC = 2
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Test port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    logic [1:0] tck_q;
    logic [4:0] tms_hist_q;
    logic [7:0] high_cnt_q;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) tck_q <= 2'h0;
        else tck_q <= {tck_q[0], tck};
    end

    // Mode select as seen at each device rise, newest in bit 0
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) tms_hist_q <= 5'h1f;
        else if (tck && !tck_q[0]) tms_hist_q <= {tms_hist_q[3:0], tms};
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) high_cnt_q <= 8'h0;
        else if (tck) high_cnt_q <= high_cnt_q + 8'h1;
        else high_cnt_q <= 8'h0;
    end

    tdo_at_fall_a: assert property (
        $changed(tdo) |-> !tck_q[0] && tck_q[1])
        else $error("serial out moved away from the falling edge");
    oe_at_fall_a: assert property (
        $changed(tdo_oe) |-> !tck_q[0] && tck_q[1])
        else $error("serial out enable moved away from the falling edge");
    tms_low_a: assert property (
        $changed(tms) |-> !tck && !tck_q[0])
        else $error("mode select changed while clock high");
    tdi_low_a: assert property (
        $changed(tdi) |-> !tck && !tck_q[0])
        else $error("serial in changed while clock high");
    tck_high_a: assert property (
        $fell(tck) |-> high_cnt_q == 8'(HALF_CYC))
        else $error("test clock high time wrong");
    shift_enter_a: assert property (
        $rose(tdo_oe) |-> tms_hist_q[1:0] == 2'b00)
        else $error("serial out enabled outside a shift state");
    shift_leave_a: assert property (
        $fell(tdo_oe) |-> tms_hist_q[1:0] == 2'b01)
        else $error("serial out released outside exit");
    ir_capture_a: assert property (
        $rose(tdo_oe) && tms_hist_q == 5'b01100 |-> tdo)
        else $error("first captured instruction bit not one");

    ir_entry_c: cover property ($rose(tdo_oe) && tms_hist_q == 5'b01100);
    shift_exit_c: cover property ($fell(tdo_oe));
    tck_fall_c: cover property ($fell(tck));
endmodule : scan_port_props

// ---- dv/tb_boundary_scan_pattern_engine.sv ----
// Bench: controller and scan device joined, scans and boundary runs
`timescale 1ns/1ps
`define CHECK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) begin \
            failures++; \
            $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
        end \
    end
module tb_boundary_scan_pattern_engine;
    import scan_test_pkg::*;
    localparam int HC = 2;
    localparam int NT = 10;
    logic        i_clk;
    logic        i_reset_n;
    logic        req, tms_b, tdi_b, ready, done, tdo_b, tdo_valid;
    logic        en_ab_n, en_ba_n;
    logic [19:0] a_pins, b_pins, a_out, b_out, a_oe, b_oe;
    logic [39:0] exp_cells, got;
    logic [19:0] pins_exp, sig;
    logic [2:0]  prev_code;
    logic        q;
    int          failures = 0;
    int          n_tests = 0;
    // Last entry runs with equal enables; the one before has a zero seed
    logic [2:0]  codes [NT] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7,
                                3'h4, 3'h5, 3'h6, 3'h1, 3'h0};
    logic [39:0] seeds [NT] = '{40'h12_3456_789a, 40'h80_0000_0001,
        40'h5a_5a5a_5a5a, 40'h80_0010_1234, 40'hff_fff0_0000,
        40'h00_0f00_00f0, 40'hc3_0000_1111, 40'h33_3330_0000,
        40'h00_0000_0000, 40'h12_3456_789a};

    test_port_if port_if();

    test_bus_controller #(.HALF_CYC(HC)) test_bus_controller_inst (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .tp(port_if.ctrl),
        .i_req(req), .i_tms(tms_b), .i_tdi(tdi_b), .o_ready(ready),
        .o_done(done), .o_tdo(tdo_b), .o_tdo_valid(tdo_valid));

    boundary_scan_pattern_engine boundary_scan_pattern_engine_inst (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .tp(port_if.dev),
        .i_a_to_b_output_enable_n(en_ab_n),
        .i_b_to_a_output_enable_n(en_ba_n),
        .i_a_pins(a_pins), .o_a_pins(a_out), .o_a_oe(a_oe),
        .i_b_pins(b_pins), .o_b_pins(b_out), .o_b_oe(b_oe));

    scan_port_props #(.HALF_CYC(HC)) scan_port_props_inst (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .tck(port_if.tck),
        .tms(port_if.tms), .tdi(port_if.tdi), .tdo(port_if.tdo),
        .tdo_oe(port_if.tdo_oe));

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic summarize();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // One test clock; the request is held until the taking edge
    task automatic step(input logic m, input logic d, output logic r);
        int k;
        req = 1'b1;
        tms_b = m;
        tdi_b = d;
        k = 0;
        while (ready !== 1'b1 && k < 50) begin
            @(posedge i_clk);
            #1;
            k++;
        end
        `CHECK("ready", 1'b1, ready)
        @(posedge i_clk);
        #1;
        req = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 50) begin
            @(posedge i_clk);
            #1;
            k++;
        end
        `CHECK("done", 1'b1, done)
        r = tdo_b;
        // Shadow and pins land after the fall is seen
        repeat (2) @(posedge i_clk);
        #1;
    endtask : step

    // From idle through an instruction scan back to idle
    task automatic load_ir(input logic [7:0] op);
        logic [7:0] cap;
        logic       r;
        step(1'b1, 1'b0, r);
        step(1'b1, 1'b0, r);
        step(1'b0, 1'b0, r);
        step(1'b0, 1'b0, r);
        for (int i = 0; i < 8; i++) begin
            step(i == 7, op[i], r);
            cap[i] = r;
        end
        `CHECK("instruction capture", IR_CAPTURE, cap)
        `CHECK("serial out enable", 1'b1, tdo_valid)
        step(1'b1, 1'b0, r);
        `CHECK("serial out release", 1'b0, tdo_valid)
        step(1'b0, 1'b0, r);
    endtask : load_ir

    task automatic shift_dr(input int n, input logic [39:0] d,
                            output logic [39:0] o);
        logic r;
        o = 40'h0;
        step(1'b1, 1'b0, r);
        step(1'b0, 1'b0, r);
        step(1'b0, 1'b0, r);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i], r);
            o[i] = r;
        end
        step(1'b1, 1'b0, r);
        step(1'b0, 1'b0, r);
    endtask : shift_dr

    initial begin
        repeat (60000) @(posedge i_clk);
        failures++;
        $display("[FAIL] watchdog expected finish seen hang");
        summarize();
    end

    initial begin
        i_reset_n = 1'b0;
        req = 1'b0;
        tms_b = 1'b1;
        tdi_b = 1'b0;
        en_ab_n = 1'b0;
        en_ba_n = 1'b1;
        a_pins = 20'h3c5a1;
        b_pins = 20'h0f0f0;
        repeat (4) @(posedge i_clk);
        #1;
        i_reset_n = 1'b1;
        step(1'b0, 1'b0, q);
        `CHECK("a enables", 20'h0, a_oe)
        `CHECK("b enables", 20'hfffff, b_oe)
        `CHECK("normal b pins", a_pins, b_out)
        `CHECK("normal a pins", b_pins, a_out)
        prev_code = CTRL_RESET;
        for (int t = 0; t < NT; t++) begin
            load_ir(OP_CONTROL);
            shift_dr(3, {37'h0, codes[t]}, got);
            `CHECK("control readback", prev_code, got[2:0])
            prev_code = codes[t];
            load_ir(OP_BOUNDARY);
            shift_dr(40, seeds[t], got);
            `CHECK("captured a pins", a_pins, got[19:0])
            `CHECK("captured b pins", b_pins, got[39:20])
            load_ir(OP_RUN_TEST);
            exp_cells = seeds[t];
            `CHECK("seed on b pins", exp_cells[39:20], b_out)
            // Equal enables must freeze the run
            if (t == NT - 1) en_ab_n = 1'b1;
            for (int s = 0; s < 5; s++) begin
                step(1'b0, 1'b0, q);
                sig = {exp_cells[18:0], 1'b0}
                    ^ (exp_cells[19] ? TAPS20 : 20'h0) ^ a_pins;
                if (t == NT - 1) begin
                end else if (codes[t] == CTRL_SIG_RAND) begin
                    exp_cells[39:20] = {exp_cells[38:20], 1'b0}
                        ^ (exp_cells[39] ? TAPS20 : 20'h0);
                    exp_cells[19:0] = sig;
                end else if (codes[t] == CTRL_SIG_CNT) begin
                    exp_cells = {exp_cells[39:20] + 20'h1, sig};
                end else if (codes[t][1:0] == CTRL_TOGGLE) begin
                    exp_cells = {~exp_cells[39:20], a_pins};
                end else if (codes[t][1:0] == CTRL_RANDOM) begin
                    exp_cells = {exp_cells[38:0], 1'b0}
                        ^ (exp_cells[39] ? TAPS40 : 40'h0);
                end else begin
                    exp_cells = {exp_cells[38:0], 1'b0}
                        ^ (exp_cells[39] ? TAPS40 : 40'h0)
                        ^ {20'h0, a_pins};
                end
                // The 40-bit signature leaves the pins on the seed
                pins_exp = (codes[t][1:0] == CTRL_SIGN) ? seeds[t][39:20]
                                                        : exp_cells[39:20];
                `CHECK("b pins", pins_exp, b_out)
                `CHECK("a pins", seeds[t][19:0], a_out)
                // Signatures never reach a pin; read the cells directly
                got = boundary_scan_pattern_engine_inst.bnd_q;
                `CHECK("cells", exp_cells, got)
            end
            en_ab_n = 1'b0;
            $display("test %0d code %0h done", t, codes[t]);
        end
        summarize();
    end
endmodule : tb_boundary_scan_pattern_engine
